// ### inc/pwu_pkg.sv
// Package: register map, field positions, reset values and mode codes
// Assumes: used with package::name only, no import
package pwu_pkg;
  localparam logic [3:0] OFF_WAKE_CTRL  = 4'h0;
  localparam logic [3:0] OFF_RST_CTRL   = 4'h4;
  localparam logic [3:0] OFF_SNAP       = 4'h8;
  localparam logic [3:0] OFF_PRESCALE   = 4'hc;
  localparam int         FLAG_BIT       = 7;
  localparam int         ACK_BIT        = 6;
  localparam int         PAGE_BIT       = 7;
  localparam logic [5:0] INTERVAL_RST   = 6'h3f;
  localparam logic [5:0] PRESCALE_RST   = 6'h1f;
  localparam logic [5:0] DIVIDER_PRESET = 6'h3f;
  localparam int         PRESCALE_BASE  = 504;
  localparam int         PRESCALE_STEP  = 16;
  localparam int         LFO_PERIOD_NS  = 1000000;
  localparam int         CLK_PERIOD_NS  = 100;
  localparam int         LFO_CYCLES     = LFO_PERIOD_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {MODE_RUN, MODE_LIGHT_STOP, MODE_DEEP_STOP} mode_t;
endpackage

// ### src/pwu_tick_gen.sv
// Tick generator: LFO enable from the system clock, then prescaled tick
// Assumes: single clock domain, freeze halts both stages
`timescale 1ns/1ns
`default_nettype none
module pwu_tick_gen #(
  parameter int LFO_CYCLES = pwu_pkg::LFO_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       por_i,
  input  wire logic       run_i,
  input  wire logic [5:0] prescale_i,
  output logic            tick_o
);
  if (LFO_CYCLES < 1) begin : g_lfo_check
    $error("LFO_CYCLES must be at least 1");
  end

  logic [31:0] lfo_cnt_q;
  logic [10:0] pre_cnt_q;
  logic        lfo_en;
  logic [10:0] pre_limit;

  assign lfo_en    = run_i && (lfo_cnt_q == 32'(LFO_CYCLES - 1));
  assign pre_limit = 11'(pwu_pkg::PRESCALE_BASE - 1) + 11'({prescale_i, 4'h0});

  always_ff @(posedge clk_i) begin
    if (rst_i && por_i) begin
      lfo_cnt_q <= 32'h0;
    end else if (run_i) begin
      lfo_cnt_q <= lfo_en ? 32'h0 : lfo_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i && por_i) begin
      pre_cnt_q <= 11'h0;
      tick_o    <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (lfo_en) begin
        if (pre_cnt_q >= pre_limit) begin
          pre_cnt_q <= 11'h0;
          tick_o    <= 1'b1;
        end else begin
          pre_cnt_q <= pre_cnt_q + 11'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### src/pwu_top.sv
// Periodic wakeup and periodic reset unit with APB register slave
// Assumes: APB master on SYS_CLK_I, reset kind given beside RST_I
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pwu_top #(
  parameter int LFO_CYCLES = pwu_pkg::LFO_CYCLES
) (
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        RST_POR_I,
  input  wire logic        RST_FROM_STOP_I,
  // Operating mode
  input  wire logic [1:0]  MODE_I,
  input  wire logic        DEBUG_FREEZE_I,
  // APB
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [3:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // System requests
  output logic             WAKE_IRQ_O,
  output logic             PERIODIC_RESET_O,
  output logic             CLOCK_RESTART_O,
  output logic             DEEP_STOP_EXIT_O,
  output logic             RESET_SOURCE_POR_ONLY_O
);
  ////////////////////////////////////////////////////////////////////////////
  logic       wake_flag_q;
  logic       periodic_reset_flag_q;
  logic [5:0] wake_interval_q;
  logic [5:0] reset_interval_q;
  logic [5:0] tick_prescale_q;
  logic       page_select_q;
  logic [5:0] counter_snapshot_q;
  logic [5:0] wake_cnt_q;
  logic [5:0] rst_cnt_q;
  logic       ev_wake_q;
  logic       ev_rst_q;
  logic       tick;
  logic       run;
  logic       wake_ev;
  logic       rst_ev;
  logic       wr;
  logic       rd;
  logic [5:0] wdat;
  logic       wr_wake;
  logic       wr_rst;
  logic       wake_wr_ok;
  logic       rst_wr_ok;

  assign run  = !DEBUG_FREEZE_I;
  assign wr   = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd   = PSEL_I && PENABLE_I && !PWRITE_I;
  assign wdat = PWDATA_I[5:0];
  assign wr_wake = wr && (PADDR_I == pwu_pkg::OFF_WAKE_CTRL);
  assign wr_rst  = wr && (PADDR_I == pwu_pkg::OFF_RST_CTRL);
  // Interlock keeps at least one of the two intervals alive
  assign wake_wr_ok = (wdat != 6'h0) || (reset_interval_q != 6'h0);
  assign rst_wr_ok  = (wdat != 6'h0) || (wake_interval_q != 6'h0);

  pwu_tick_gen #(.LFO_CYCLES(LFO_CYCLES)) u_tick (
    .clk_i      (SYS_CLK_I),
    .rst_i      (RST_I),
    .por_i      (RST_POR_I),
    .run_i      (run),
    .prescale_i (tick_prescale_q),
    .tick_o     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wakeup counter
  assign wake_ev = tick && run && !RST_I && (wake_interval_q != 6'h0) &&
                   (wake_cnt_q + 6'h1 >= wake_interval_q);

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      wake_cnt_q <= 6'h0;
    end else if (wr_wake && wake_wr_ok && wdat != wake_interval_q) begin
      wake_cnt_q <= (wdat == 6'h0) ? pwu_pkg::DIVIDER_PRESET : 6'h0;
    end else if (wake_ev) begin
      wake_cnt_q <= 6'h0;
    end else if (tick && run && wake_interval_q != 6'h0) begin
      wake_cnt_q <= wake_cnt_q + 6'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Periodic reset counter, clocked by wakeup events
  assign rst_ev = wake_ev && (reset_interval_q != 6'h0) &&
                  (rst_cnt_q + 6'h1 >= reset_interval_q);

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      rst_cnt_q <= 6'h0;
    end else if (wr_rst && rst_wr_ok && wdat != reset_interval_q) begin
      rst_cnt_q <= 6'h0;
    end else if (rst_ev) begin
      rst_cnt_q <= 6'h0;
    end else if (wake_ev && reset_interval_q != 6'h0) begin
      rst_cnt_q <= rst_cnt_q + 6'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval registers
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      wake_interval_q  <= pwu_pkg::INTERVAL_RST;
      reset_interval_q <= pwu_pkg::INTERVAL_RST;
    end else begin
      if (wr_wake && wake_wr_ok) begin
        wake_interval_q <= wdat;
      end
      if (wr_rst && rst_wr_ok) begin
        reset_interval_q <= wdat;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I && RST_POR_I && !RST_FROM_STOP_I) begin
      tick_prescale_q <= pwu_pkg::PRESCALE_RST;
    end else if (!RST_I && wr && PADDR_I == pwu_pkg::OFF_PRESCALE) begin
      tick_prescale_q <= wdat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: set wins over acknowledge
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      wake_flag_q <= 1'b0;
    end else if (wake_ev) begin
      wake_flag_q <= 1'b1;
    end else if (wr_wake && PWDATA_I[pwu_pkg::ACK_BIT]) begin
      wake_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I && RST_POR_I && !ev_rst_q) begin
      periodic_reset_flag_q <= 1'b0;
    end else if (rst_ev) begin
      periodic_reset_flag_q <= 1'b1;
    end else if (!RST_I && wr_rst && PWDATA_I[pwu_pkg::ACK_BIT]) begin
      periodic_reset_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page select and snapshot
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I && RST_POR_I && !RST_FROM_STOP_I) begin
      page_select_q <= 1'b0;
    end else if (!RST_I && wr && PADDR_I == pwu_pkg::OFF_SNAP) begin
      page_select_q <= PWDATA_I[pwu_pkg::PAGE_BIT];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      counter_snapshot_q <= 6'h0;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == pwu_pkg::OFF_SNAP) begin
      counter_snapshot_q <= page_select_q ? rst_cnt_q : wake_cnt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read data
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I &&
                     !(PADDR_I inside {pwu_pkg::OFF_WAKE_CTRL, pwu_pkg::OFF_RST_CTRL,
                                       pwu_pkg::OFF_SNAP, pwu_pkg::OFF_PRESCALE});

  always_comb begin
    PRDATA_O = 32'h0;
    if (rd) begin
      unique case (PADDR_I)
        pwu_pkg::OFF_WAKE_CTRL: PRDATA_O = {24'h0, wake_flag_q, 1'b0, wake_interval_q};
        pwu_pkg::OFF_RST_CTRL:  PRDATA_O = {24'h0, periodic_reset_flag_q, 1'b0, reset_interval_q};
        pwu_pkg::OFF_SNAP:      PRDATA_O = {24'h0, page_select_q, 1'b0, counter_snapshot_q};
        pwu_pkg::OFF_PRESCALE:  PRDATA_O = {26'h0, tick_prescale_q};
        default:                PRDATA_O = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System requests
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ev_wake_q <= 1'b0;
    end else begin
      ev_wake_q <= wake_ev;
    end
  end

  // Event memory survives the reset it causes
  always_ff @(posedge SYS_CLK_I) begin
    if (rst_ev) begin
      ev_rst_q <= 1'b1;
    end else if (!RST_I || (RST_POR_I && !RST_FROM_STOP_I)) begin
      ev_rst_q <= 1'b0;
    end
  end

  assign WAKE_IRQ_O       = wake_flag_q;
  assign PERIODIC_RESET_O = rst_ev;
  assign CLOCK_RESTART_O  = (wake_ev || rst_ev) &&
                            (MODE_I == 2'(pwu_pkg::MODE_LIGHT_STOP));
  assign DEEP_STOP_EXIT_O = (wake_ev || rst_ev) &&
                            (MODE_I == 2'(pwu_pkg::MODE_DEEP_STOP));
  assign RESET_SOURCE_POR_ONLY_O = rst_ev &&
                                   (MODE_I == 2'(pwu_pkg::MODE_DEEP_STOP));

  ////////////////////////////////////////////////////////////////////////////
  property p_flag_set;
    @(posedge SYS_CLK_I) disable iff (RST_I) rst_ev |=> periodic_reset_flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("reset flag not set");
  property p_ack;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      wr_rst && PWDATA_I[6] && !rst_ev |=> !periodic_reset_flag_q;
  endproperty
  a_ack: assert property (p_ack) else $error("reset flag not cleared");
  property p_no_double_zero;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      !(wake_interval_q == 6'h0 && reset_interval_q == 6'h0);
  endproperty
  a_no_double_zero: assert property (p_no_double_zero) else $error("both intervals zero");
  property p_pulse;
    @(posedge SYS_CLK_I) disable iff (RST_I) PERIODIC_RESET_O |=> !PERIODIC_RESET_O;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset request longer than one cycle");
  property p_freeze;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      DEBUG_FREEZE_I && !wr |=> $stable(wake_cnt_q) && $stable(rst_cnt_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved in debug");
  property p_wake_irq;
    @(posedge SYS_CLK_I) disable iff (RST_I) wake_ev |=> WAKE_IRQ_O;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake irq missing");
  property p_reload;
    @(posedge SYS_CLK_I) disable iff (RST_I) wake_ev && !wr |=> wake_cnt_q == 6'h0;
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded");
  property p_bit6;
    @(posedge SYS_CLK_I) disable iff (RST_I) rd |-> PRDATA_O[6] == 1'b0;
  endproperty
  a_bit6: assert property (p_bit6) else $error("bit 6 not zero");

  // Interlock, restart and reset survival
  property p_rst_on_wake;
    @(posedge SYS_CLK_I) disable iff (RST_I) rst_ev |-> wake_ev;
  endproperty
  a_rst_on_wake: assert property (p_rst_on_wake) else $error("reset request without wakeup");
  property p_restart;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      wr_rst && rst_wr_ok && wdat != reset_interval_q |=> rst_cnt_q == 6'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("reset count not restarted");
  property p_same_value;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      wr_rst && wdat == reset_interval_q && !wake_ev |=> $stable(rst_cnt_q);
  endproperty
  a_same_value: assert property (p_same_value) else $error("same interval moved the count");
  property p_refuse_rst;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      wr_rst && wdat == 6'h0 && wake_interval_q == 6'h0 |=> $stable(reset_interval_q);
  endproperty
  a_refuse_rst: assert property (p_refuse_rst) else $error("zero reset interval accepted");
  property p_refuse_wake;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      wr_wake && wdat == 6'h0 && reset_interval_q == 6'h0 |=> $stable(wake_interval_q);
  endproperty
  a_refuse_wake: assert property (p_refuse_wake) else $error("zero wake interval accepted");
  property p_preset;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      wr_wake && wdat == 6'h0 && reset_interval_q != 6'h0 && wake_interval_q != 6'h0 |=>
      wake_cnt_q == pwu_pkg::DIVIDER_PRESET;
  endproperty
  a_preset: assert property (p_preset) else $error("wake divider not preset");
  property p_flag_write;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      wr_rst && !PWDATA_I[6] && !rst_ev |=> $stable(periodic_reset_flag_q);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("reset flag moved by write");
  property p_warm_keep;
    @(posedge SYS_CLK_I) RST_I && !RST_POR_I |=> $stable(periodic_reset_flag_q);
  endproperty
  a_warm_keep: assert property (p_warm_keep) else $error("reset flag lost on warm reset");
  property p_page_keep;
    @(posedge SYS_CLK_I) RST_I && !(RST_POR_I && !RST_FROM_STOP_I) |=> $stable(page_select_q);
  endproperty
  a_page_keep: assert property (p_page_keep) else $error("page select lost on reset");
  property p_deep_rst;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      rst_ev && MODE_I == 2'(pwu_pkg::MODE_DEEP_STOP) |-> DEEP_STOP_EXIT_O && RESET_SOURCE_POR_ONLY_O;
  endproperty
  a_deep_rst: assert property (p_deep_rst) else $error("deep stop reset exit missing");
  property p_irq_level;
    @(posedge SYS_CLK_I) disable iff (RST_I) ev_wake_q |-> WAKE_IRQ_O;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("wake irq not held");

  // Main scenarios
  c_wake: cover property (@(posedge SYS_CLK_I) wake_ev);
  c_rst: cover property (@(posedge SYS_CLK_I) rst_ev);
  c_refuse: cover property (@(posedge SYS_CLK_I) wr_rst && !rst_wr_ok);
  c_light: cover property (@(posedge SYS_CLK_I) CLOCK_RESTART_O);
  c_deep: cover property (@(posedge SYS_CLK_I) DEEP_STOP_EXIT_O);
endmodule
`default_nettype wire

// ### verification/pwu_sys_model.sv
// Model of the core and reset logic facing the unit
// Assumes: one clock, requests sampled at the rising edge
`timescale 1ns/1ns
`default_nettype none
module pwu_sys_model (
  // Clock
  input  wire logic clk_i,
  // Requests from the unit
  input  wire logic periodic_reset_i,
  // Warm reset back to the unit, request count to the bench
  output logic      rst_req_o,
  output var int    pulses_o
);
  initial begin
    rst_req_o = 1'b0;
    pulses_o  = 0;
  end
  // Warm reset one cycle after each periodic request
  always @(posedge clk_i) begin
    rst_req_o <= periodic_reset_i;
    if (periodic_reset_i) begin
      pulses_o <= pulses_o + 1;
    end
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench of the periodic wake and reset unit
// Assumes: APB slave with zero wait, LFO_CYCLES shortened to 2
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b1, por = 1'b1, freeze = 1'b0, stp = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic        psel = 1'b0, pen = 1'b0, pw = 1'b0;
  logic [3:0]  pa = 4'h0;
  logic [31:0] pwd = 32'h0, rd, prdata;
  logic        pready, pslverr, slverr, irq, prst, restart, dexit, por_only, rst_req;
  int          pulses, fails = 0, checks_done = 0;
  bit          hit;
  always #50 clk = ~clk;
  pwu_top #(.LFO_CYCLES(2)) pwu_top_inst (
    .SYS_CLK_I(clk), .RST_I(rst_b | rst_req), .RST_POR_I(por), .RST_FROM_STOP_I(stp),
    .MODE_I(mode), .DEBUG_FREEZE_I(freeze), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pw),
    .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .WAKE_IRQ_O(irq), .PERIODIC_RESET_O(prst), .CLOCK_RESTART_O(restart),
    .DEEP_STOP_EXIT_O(dexit), .RESET_SOURCE_POR_ONLY_O(por_only));
  pwu_sys_model pwu_sys_model_inst (.clk_i(clk), .periodic_reset_i(prst), .rst_req_o(rst_req),
    .pulses_o(pulses));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen  <= 1'b0;
    pw   <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd     = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("register read", e, rd[7:0] & m)
  endtask
  // Wait for one event line under a bound
  task automatic wt(input int k, input int n);
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      @(posedge clk);
      case (k)
        0: hit = (irq === 1'b1);
        1: hit = (prst === 1'b1);
        2: hit = (restart === 1'b1);
        default: hit = (dexit === 1'b1);
      endcase
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b0;
    por   <= 1'b0;
    @(posedge clk);
    rchk(4'h4, 8'hff, 8'h3f);
    rchk(4'h0, 8'hff, 8'h3f);
    rchk(4'h8, 8'hc0, 8'h00);
    apb(1'b0, 4'h2, 32'h0);
    `CHK("unmapped error", 1'b1, slverr)
    $display("test reset values done");
    wr(4'h0, 8'h00);
    rchk(4'h0, 8'h3f, 8'h00);
    wr(4'h4, 8'h00);
    rchk(4'h4, 8'h3f, 8'h3f);
    wr(4'h0, 8'h01);
    wr(4'h4, 8'h00);
    rchk(4'h4, 8'h3f, 8'h00);
    wr(4'h0, 8'h00);
    rchk(4'h0, 8'h3f, 8'h01);
    wr(4'h4, 8'h80);
    rchk(4'h4, 8'hff, 8'h00);
    $display("test interlock done");
    wr(4'hc, 8'h00);
    wr(4'h4, 8'h02);
    wr(4'h8, 8'h80);
    wt(0, 5000);
    `CHK("wake event", 1'b1, hit)
    rchk(4'h0, 8'h80, 8'h80);
    wr(4'h0, 8'h41);
    `CHK("wake irq cleared", 1'b0, irq)
    wt(1, 5000);
    `CHK("periodic reset", 1'b1, hit)
    repeat (3) @(posedge clk);
    `CHK("one pulse", 1, pulses)
    rchk(4'h4, 8'hff, 8'hbf);
    rchk(4'h8, 8'hff, 8'h80);
    wr(4'h4, 8'h7f);
    rchk(4'h4, 8'hff, 8'h3f);
    $display("test run mode done");
    wr(4'h0, 8'h41);
    freeze <= 1'b1;
    wt(0, 2500);
    `CHK("frozen", 1'b0, hit)
    freeze <= 1'b0;
    wt(0, 2500);
    `CHK("resumed", 1'b1, hit)
    $display("test freeze done");
    for (int m = 1; m <= 2; m++) begin
      wr(4'h0, 8'h41);
      mode <= m[1:0];
      wt(m + 1, 2500);
      `CHK("stop exit event", 1'b1, hit)
      @(posedge clk);
      `CHK("irq pending", 1'b1, irq)
      mode <= 2'h0;
      @(posedge clk);
    end
    rchk(4'h0, 8'h3f, 8'h01);
    $display("test stop modes done");
    wr(4'h8, 8'h80);
    wr(4'h4, 8'h3f);
    rchk(4'h8, 8'h3f, 8'h03);
    wr(4'h4, 8'h3e);
    rchk(4'h8, 8'h3f, 8'h00);
    $display("test restart done");
    for (int k = 0; k < 2; k++) begin
      rst_b <= 1'b1;
      por   <= 1'b1;
      stp   <= (k == 0);
      repeat (3) @(posedge clk);
      rst_b <= 1'b0;
      por   <= 1'b0;
      stp   <= 1'b0;
      @(posedge clk);
      rchk(4'h8, 8'h80, (k == 0) ? 8'h80 : 8'h00);
    end
    $display("test power-on done");
    results();
  end
endmodule
`default_nettype wire
